// ==== logic/feu_pkg.sv ====
/*
 Shared constants and types of the float exception unit: exception bit
 positions, control and status field positions, reset values, response
 codes, instruction phase states and the register map seen over Avalon-MM.
 Assumes 32-bit Avalon-MM data with word addressing in bytes.
*/
package feu_pkg;
   // Exception bit positions, in status and control word alike
   localparam int EX_INV = 0;
   localparam int EX_DEN = 1;
   localparam int EX_ZDV = 2;
   localparam int EX_OVF = 3;
   localparam int EX_UNF = 4;
   localparam int EX_PRE = 5;
   localparam int EX_N = 6;
   // Control word fields
   localparam int CTL_IEM = 7;
   localparam int CTL_ICS = 12;
   localparam logic [15:0] CTL_RESET = 16'h003F;
   // Status word field
   localparam int STS_IRQ = 7;
   // Closure models
   localparam logic CLOSE_PROJ = 1'b0;
   localparam logic CLOSE_AFF = 1'b1;
   // Exponent bias adjustment for unmasked over/underflow, 24576 decimal
   localparam logic [14:0] EXP_ADJ = 15'h6000;
   // Response codes
   typedef enum logic [2:0] {
      feu_rsp_none = 3'h0,
      feu_rsp_nan_pass = 3'h1,
      feu_rsp_nan_big = 3'h2,
      feu_rsp_indef = 3'h3,
      feu_rsp_inf = 3'h4,
      feu_rsp_denorm = 3'h5,
      feu_rsp_round = 3'h6,
      feu_rsp_trap = 3'h7
   } feu_rsp_t;
   // Instruction phase states
   typedef enum logic [3:0] {
      feu_idle = 4'h1,
      feu_before = 4'h2,
      feu_after = 4'h4,
      feu_done = 4'h8
   } feu_state_t;
   // Register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_RESP = 4'h8;
   localparam logic [3:0] REG_CMD = 4'hC;
   // Command bits written to REG_CMD
   localparam int CMD_CLEX = 0;
   localparam int CMD_INIT = 1;
   localparam int CMD_LDSTS = 2;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage

// ==== logic/feu_prio.sv ====
/*
 Picks the one exception to signal from a set of coincident internal
 flags, in the fixed priority order, given the exception masks.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module feu_prio (
   input wire logic [5:0] pending,
   input wire logic [5:0] mask,
   output logic [5:0] chosen
);
   always_comb begin
      chosen = '0;
      if (pending[feu_pkg::EX_DEN] && !mask[feu_pkg::EX_DEN]) begin
         chosen[feu_pkg::EX_DEN] = 1'b1;
      end else if (pending[feu_pkg::EX_INV]) begin
         chosen[feu_pkg::EX_INV] = 1'b1;
      end else if (pending[feu_pkg::EX_ZDV]) begin
         chosen[feu_pkg::EX_ZDV] = 1'b1;
      end else if (pending[feu_pkg::EX_DEN]) begin
         chosen[feu_pkg::EX_DEN] = 1'b1;
      end else if (pending[feu_pkg::EX_OVF]) begin
         chosen[feu_pkg::EX_OVF] = 1'b1;
      end else if (pending[feu_pkg::EX_UNF]) begin
         chosen[feu_pkg::EX_UNF] = 1'b1;
      end else if (pending[feu_pkg::EX_PRE]) begin
         chosen[feu_pkg::EX_PRE] = 1'b1;
      end
   end
endmodule // feu_prio

// ==== logic/feu_detect.sv ====
/*
 Classifies operand and result conditions into the six exception
 classes, split into before-operation and after-result groups.
 Operand tags come from the datapath, synchronous to ref_clk.
*/
`timescale 1ns/1ps
module feu_detect (
   input wire logic load_full,
   input wire logic pop_empty,
   input wire logic nan_a,
   input wire logic nan_b,
   input wire logic indeterminate,
   input wire logic divide,
   input wire logic zero_a,
   input wire logic zero_b,
   input wire logic inf_a,
   input wire logic den_a,
   input wire logic den_b,
   input wire logic exp_high,
   input wire logic exp_low,
   input wire logic inexact,
   output logic [5:0] before_ex,
   output logic [5:0] after_ex
);
   always_comb begin
      before_ex = '0;
      after_ex = '0;
      before_ex[feu_pkg::EX_INV] = load_full | pop_empty | nan_a | nan_b
         | indeterminate | (divide & zero_a & zero_b);
      before_ex[feu_pkg::EX_ZDV] = divide & zero_b & !zero_a & !inf_a & !nan_a;
      before_ex[feu_pkg::EX_DEN] = den_a | den_b;
      after_ex[feu_pkg::EX_OVF] = exp_high;
      after_ex[feu_pkg::EX_UNF] = exp_low;
      after_ex[feu_pkg::EX_PRE] = inexact;
   end
endmodule // feu_detect

// ==== logic/feu_unit.sv ====
/*
 Float exception unit top. Holds the control and status words, runs the
 before/after exception phases of one instruction, chooses masked or
 unmasked responses and drives the interrupt request to the host.
 Assumes an Avalon-MM master on ref_clk and a datapath that pulses
 instr_start with stable operand tags and later result_valid.
*/
`timescale 1ns/1ps
module feu_unit (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic instr_start,
   input wire logic store_op,
   input wire logic mem_operand,
   input wire logic load_full,
   input wire logic pop_empty,
   input wire logic nan_a,
   input wire logic nan_b,
   input wire logic nan_a_larger,
   input wire logic indeterminate,
   input wire logic divide,
   input wire logic zero_a,
   input wire logic zero_b,
   input wire logic inf_a,
   input wire logic inf_b,
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic den_a,
   input wire logic den_b,
   input wire logic result_valid,
   input wire logic exp_high,
   input wire logic exp_low,
   input wire logic inexact,
   input wire logic result_sign,
   input wire logic [14:0] result_exp,
   output logic [2:0] response,
   output logic nan_pick_b,
   output logic result_inf_sign,
   output logic renormalise,
   output logic commit_ok,
   output logic abort_op,
   output logic [14:0] adjusted_exp,
   output logic infinity_closure_select,
   output logic infinities_equal,
   output logic cpu_int
);
   logic [15:0] ctrl;
   logic [5:0] sticky;
   logic interrupt_request_flag;
   logic [5:0] inst_flags;
   logic [5:0] before_ex;
   logic [5:0] after_ex;
   logic [5:0] chosen;
   logic [5:0] pending;
   logic [5:0] masks;
   logic [5:0] new_flags;
   logic unmasked;
   logic interrupt_block_mask;
   logic clear_exceptions_instruction;
   logic reinit;
   logic load_environment_instruction;
   logic wr_ok;
   logic rd_pend;
   feu_pkg::feu_state_t state;
   feu_pkg::feu_state_t next_state;
   feu_pkg::feu_rsp_t next_rsp;

   assign masks = ctrl[feu_pkg::EX_N-1:0];
   assign interrupt_block_mask = ctrl[feu_pkg::CTL_IEM];
   assign wr_ok = clk_en & avs_write & !avs_waitrequest;
   assign clear_exceptions_instruction = wr_ok & (avs_address == feu_pkg::REG_CMD)
      & avs_writedata[feu_pkg::CMD_CLEX];
   assign reinit = wr_ok & (avs_address == feu_pkg::REG_CMD)
      & avs_writedata[feu_pkg::CMD_INIT];
   assign load_environment_instruction = wr_ok & (avs_address == feu_pkg::REG_STAT);

   feu_detect u_detect (
      .load_full(load_full),
      .pop_empty(pop_empty),
      .nan_a(nan_a),
      .nan_b(nan_b),
      .indeterminate(indeterminate),
      .divide(divide),
      .zero_a(zero_a),
      .zero_b(zero_b),
      .inf_a(inf_a),
      .den_a(den_a),
      .den_b(den_b),
      .exp_high(exp_high),
      .exp_low(exp_low),
      .inexact(inexact),
      .before_ex(before_ex),
      .after_ex(after_ex)
   );

   // Only the phase in progress contributes candidates
   always_comb begin
      pending = '0;
      if (state == feu_pkg::feu_before) begin
         pending = before_ex;
      end else if (state == feu_pkg::feu_after) begin
         pending = after_ex;
      end
   end

   feu_prio u_prio (
      .pending(pending),
      .mask(masks),
      .chosen(chosen)
   );

   assign unmasked = |(chosen & ~masks);
   // Masked responses keep going: remaining masked conditions are recorded too
   assign new_flags = unmasked ? chosen : (pending & masks) | chosen;

   // Phase sequencing
   always_comb begin
      next_state = state;
      case (state)
         feu_pkg::feu_idle: begin
            if (instr_start) begin
               next_state = feu_pkg::feu_before;
            end
         end
         feu_pkg::feu_before: begin
            if (unmasked) begin
               next_state = feu_pkg::feu_done;
            end else begin
               next_state = feu_pkg::feu_after;
            end
         end
         feu_pkg::feu_after: begin
            if (result_valid) begin
               next_state = feu_pkg::feu_done;
            end
         end
         feu_pkg::feu_done: begin
            next_state = feu_pkg::feu_idle;
         end
         default: begin
            next_state = feu_pkg::feu_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= feu_pkg::feu_idle;
      end else if (clk_en) begin
         if (reinit) begin
            state <= feu_pkg::feu_idle;
         end else if (state != feu_pkg::feu_after || result_valid) begin
            state <= next_state;
         end
      end
   end

   // Per-instruction flags, cleared at each start
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         inst_flags <= '0;
      end else if (clk_en) begin
         if (reinit || (state == feu_pkg::feu_idle && instr_start)) begin
            inst_flags <= '0;
         end else if (state == feu_pkg::feu_before
                      || (state == feu_pkg::feu_after && result_valid)) begin
            inst_flags <= inst_flags | new_flags;
         end
      end
   end

   // Control word
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= feu_pkg::CTL_RESET;
      end else if (clk_en) begin
         if (reinit) begin
            ctrl <= feu_pkg::CTL_RESET;
         end else if (wr_ok && avs_address == feu_pkg::REG_CTRL) begin
            ctrl <= avs_writedata[15:0];
         end
      end
   end

   // Sticky status flags; detection wins over a same-cycle clear
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sticky <= '0;
      end else if (clk_en) begin
         if (load_environment_instruction) begin
            sticky <= avs_writedata[feu_pkg::EX_N-1:0] | new_flags;
         end else if (clear_exceptions_instruction || reinit) begin
            sticky <= new_flags;
         end else if (state == feu_pkg::feu_before
                      || (state == feu_pkg::feu_after && result_valid)) begin
            sticky <= sticky | new_flags;
         end
      end
   end

   // Status request bit
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         interrupt_request_flag <= 1'b0;
      end else if (clk_en) begin
         if ((state == feu_pkg::feu_before
              || (state == feu_pkg::feu_after && result_valid)) && unmasked) begin
            interrupt_request_flag <= 1'b1;
         end else if (load_environment_instruction) begin
            interrupt_request_flag <= avs_writedata[feu_pkg::STS_IRQ];
         end else if (clear_exceptions_instruction || reinit) begin
            interrupt_request_flag <= 1'b0;
         end
      end
   end

   // Interrupt output
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_int <= 1'b0;
      end else if (clk_en) begin
         cpu_int <= interrupt_request_flag & !interrupt_block_mask;
      end
   end

   // Response selection for the chosen exception
   always_comb begin
      next_rsp = feu_pkg::feu_rsp_none;
      if (unmasked && !chosen[feu_pkg::EX_PRE]) begin
         next_rsp = feu_pkg::feu_rsp_trap;
      end else if (chosen[feu_pkg::EX_INV]) begin
         if (nan_a && nan_b) begin
            next_rsp = feu_pkg::feu_rsp_nan_big;
         end else if (nan_a || nan_b) begin
            next_rsp = feu_pkg::feu_rsp_nan_pass;
         end else begin
            next_rsp = feu_pkg::feu_rsp_indef;
         end
      end else if (chosen[feu_pkg::EX_ZDV] || chosen[feu_pkg::EX_OVF]) begin
         next_rsp = feu_pkg::feu_rsp_inf;
      end else if (chosen[feu_pkg::EX_UNF]) begin
         next_rsp = feu_pkg::feu_rsp_denorm;
      end else if (chosen[feu_pkg::EX_PRE]) begin
         next_rsp = feu_pkg::feu_rsp_round;
      end
   end

   // Datapath response outputs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         response <= feu_pkg::feu_rsp_none;
         nan_pick_b <= 1'b0;
         result_inf_sign <= 1'b0;
         renormalise <= 1'b0;
         adjusted_exp <= '0;
      end else if (clk_en) begin
         renormalise <= 1'b0;
         if (state == feu_pkg::feu_before
             || (state == feu_pkg::feu_after && result_valid)) begin
            response <= next_rsp;
            nan_pick_b <= nan_b && (!nan_a || !nan_a_larger);
            if (chosen[feu_pkg::EX_ZDV]) begin
               result_inf_sign <= sign_a ^ sign_b;
            end else begin
               result_inf_sign <= result_sign;
            end
            // Masked register denormal is renormalised and rechecked
            renormalise <= chosen[feu_pkg::EX_DEN] && !unmasked && !mem_operand;
            if (unmasked && chosen[feu_pkg::EX_OVF]) begin
               adjusted_exp <= result_exp - feu_pkg::EXP_ADJ;
            end else if (unmasked && chosen[feu_pkg::EX_UNF]) begin
               adjusted_exp <= result_exp + feu_pkg::EXP_ADJ;
            end else begin
               adjusted_exp <= result_exp;
            end
         end
      end
   end

   // Commit / abort of the instruction's side effects
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         commit_ok <= 1'b0;
         abort_op <= 1'b0;
      end else if (clk_en) begin
         commit_ok <= 1'b0;
         abort_op <= 1'b0;
         if (state == feu_pkg::feu_before && unmasked) begin
            abort_op <= 1'b1;
         end else if (state == feu_pkg::feu_after && result_valid) begin
            if (unmasked && (chosen[feu_pkg::EX_OVF] || chosen[feu_pkg::EX_UNF])
                && (store_op || mem_operand)) begin
               abort_op <= 1'b1;
            end else begin
               commit_ok <= 1'b1;
            end
         end
      end
   end

   // Closure model outputs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         infinity_closure_select <= feu_pkg::CLOSE_PROJ;
         infinities_equal <= 1'b0;
      end else if (clk_en) begin
         infinity_closure_select <= ctrl[feu_pkg::CTL_ICS];
         if (ctrl[feu_pkg::CTL_ICS] == feu_pkg::CLOSE_PROJ) begin
            infinities_equal <= inf_a & inf_b;
         end else begin
            infinities_equal <= inf_a & inf_b & (sign_a == sign_b);
         end
      end
   end

   // Avalon-MM slave: one wait cycle, data registered
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= feu_pkg::READ_UNMAPPED;
         rd_pend <= 1'b0;
      end else if (clk_en) begin
         rd_pend <= (avs_read | avs_write) & avs_waitrequest & !rd_pend;
         avs_waitrequest <= !((avs_read | avs_write) & avs_waitrequest & !rd_pend);
         if (avs_read && avs_waitrequest && !rd_pend) begin
            if (avs_address == feu_pkg::REG_CTRL) begin
               avs_readdata <= {16'h0000, ctrl};
            end else if (avs_address == feu_pkg::REG_STAT) begin
               avs_readdata <= {24'h000000, interrupt_request_flag, 1'b0, sticky};
            end else if (avs_address == feu_pkg::REG_RESP) begin
               avs_readdata <= {20'h00000, state, 2'h0, inst_flags};
            end else begin
               avs_readdata <= feu_pkg::READ_UNMAPPED;
            end
         end
      end
   end
endmodule // feu_unit

// ==== verification/feu_unit_props.sv ====
/*
 Port checker of the float exception unit.
 Bound to feu_unit from the testbench top; one clock domain.
*/
`timescale 1ns/1ps
module feu_unit_props (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic instr_start,
   input wire logic result_valid,
   input wire logic commit_ok,
   input wire logic abort_op,
   input wire logic renormalise,
   input wire logic infinity_closure_select,
   input wire logic cpu_int
);
   logic wr_ok;
   logic ev;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign ev = abort_op || commit_ok || avs_write;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_block;
      wr_ok && avs_address == feu_pkg::REG_CTRL && avs_writedata[feu_pkg::CTL_IEM]
         |-> ##2 !cpu_int;
   endproperty
   a_block: assert property (p_block) else $error("interrupt not withheld");
   property p_closure;
      wr_ok && avs_address == feu_pkg::REG_CTRL
         |-> ##2 infinity_closure_select == $past(avs_writedata[feu_pkg::CTL_ICS], 2);
   endproperty
   a_closure: assert property (p_closure) else $error("closure select wrong");
   property p_clear;
      wr_ok && avs_address == feu_pkg::REG_CMD && avs_writedata[1:0] != 2'h0
         && !instr_start && !result_valid |-> ##2 !cpu_int;
   endproperty
   a_clear: assert property (p_clear) else $error("interrupt kept after clear");
   property p_excl;
      !(commit_ok && abort_op);
   endproperty
   a_excl: assert property (p_excl) else $error("commit and abort together");
   property p_abort;
      abort_op |=> !abort_op;
   endproperty
   a_abort: assert property (p_abort) else $error("abort longer than a pulse");
   property p_commit;
      commit_ok |=> !commit_ok;
   endproperty
   a_commit: assert property (p_commit) else $error("commit longer than a pulse");
   property p_renorm;
      renormalise |=> !renormalise;
   endproperty
   a_renorm: assert property (p_renorm) else $error("renormalise not a pulse");
   property p_cause;
      $rose(cpu_int) |-> ev || $past(ev) || $past(ev, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("interrupt without cause");
endmodule // feu_unit_props

// ==== verification/feu_host_model.sv ====
/*
 Host side of the interrupt path: counts interrupt requests seen.
 Assumes cpu_int is a level synchronous to ref_clk.
*/
`timescale 1ns/1ps
module feu_host_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cpu_int,
   output int int_count
);
   logic last;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         last <= 1'b0;
         int_count <= 0;
      end else begin
         last <= cpu_int;
         if (cpu_int && !last) begin
            int_count <= int_count + 1;
         end
      end
   end
endmodule // feu_host_model

// ==== verification/tb_float_exception_unit.sv ====
/*
 Testbench of the float exception unit: bus tasks, an instruction task and
 one task per scenario. Assumes the package, design, host model and checker.
*/
`timescale 1ns/1ps
module tb_float_exception_unit;
   localparam logic [3:0] CT = feu_pkg::REG_CTRL;
   localparam logic [3:0] ST = feu_pkg::REG_STAT;
   localparam logic [3:0] CM = feu_pkg::REG_CMD;
   logic ref_clk, reset_n, clk_en, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic instr_start, result_valid, store_op, mem_operand, load_full, pop_empty, nan_a;
   logic nan_b, nan_a_larger, indeterminate, divide, zero_a, zero_b, inf_a, inf_b, sign_a;
   logic sign_b, den_a, den_b, exp_high, exp_low, inexact, result_sign;
   logic [14:0] result_exp, adjusted_exp, ad;
   logic [2:0] response, rs;
   logic nan_pick_b, result_inf_sign, renormalise, commit_ok, abort_op;
   logic infinity_closure_select, infinities_equal, cpu_int, sg, pb, cm, ab, rn;
   logic [16:0] tg;
   logic [3:0] af;
   int miscompares, tests_run, int_count;
   assign {store_op, mem_operand, load_full, pop_empty, nan_a, nan_b, nan_a_larger,
      indeterminate, divide, zero_a, zero_b, inf_a, inf_b, sign_a, sign_b, den_a, den_b} = tg;
   assign {exp_high, exp_low, inexact, result_sign} = af;
   feu_unit u_dut (.*);
   feu_host_model u_host (.ref_clk, .reset_n, .cpu_int, .int_count);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic timeout(input string nm);
      miscompares++;
      $display("CHECK FAILED %s expected answer seen none", nm);
      tally_and_finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 20) timeout("bus");
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask
   task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(nm, e, v);
   endtask
   task automatic run(input logic [16:0] t, input logic [3:0] f, input logic [14:0] e);
      int n;
      @(posedge ref_clk);
      tg <= t;
      af <= f;
      result_exp <= e;
      instr_start <= 1'b1;
      @(posedge ref_clk);
      instr_start <= 1'b0;
      rn = 1'b0;
      rs = feu_pkg::feu_rsp_none;
      for (n = 0; n < 30; n++) begin
         if (n > 0) @(posedge ref_clk);
         if (n == 2) result_valid <= 1'b1;
         @(negedge ref_clk);
         rn = rn | renormalise;
         // Each phase posts its own response; keep the one that carries a result
         if (n > 0 && response !== feu_pkg::feu_rsp_none) begin
            {rs, sg, pb} = {response, result_inf_sign, nan_pick_b};
         end
         if (commit_ok === 1'b1 || abort_op === 1'b1) break;
      end
      if (n == 30) timeout("instruction");
      {cm, ab, ad} = {commit_ok, abort_op, adjusted_exp};
      @(posedge ref_clk);
      tg <= 17'h0;
      af <= 4'h0;
      result_valid <= 1'b0;
   endtask
   task automatic t_reset;
      rdc("ctrl", CT, 32'h0000_003F);
      rdc("stat", ST, 32'h0);
      rdc("unmapped", 4'h2, feu_pkg::READ_UNMAPPED);
      chk("closure", 0, infinity_closure_select);
      $display("test reset done");
   endtask
   task automatic t_masked;
      run(17'h003C0, 0, 0);
      chk("indef", feu_pkg::feu_rsp_indef, rs);
      rdc("stat inv", ST, 32'h01);
      rdc("inst flags", feu_pkg::REG_RESP, 32'h0000_0101);
      run(17'h01000, 0, 0);
      chk("nan pass", feu_pkg::feu_rsp_nan_pass, rs);
      run(17'h01800, 0, 0);
      chk("nan big", feu_pkg::feu_rsp_nan_big, rs);
      chk("pick b", 1, pb);
      run(17'h00148, 0, 0);
      chk("zdv inf", feu_pkg::feu_rsp_inf, rs);
      chk("zdv sign", 1, sg);
      rdc("stat zdv", ST, 32'h05);
      run(0, 4'h9, 0);
      chk("ovf inf", feu_pkg::feu_rsp_inf, rs);
      chk("ovf sign", 1, sg);
      run(0, 4'h4, 0);
      chk("unf", feu_pkg::feu_rsp_denorm, rs);
      run(0, 4'h2, 0);
      chk("round", feu_pkg::feu_rsp_round, rs);
      run(0, 0, 0);
      rdc("sticky", ST, 32'h3D);
      chk("no int", 0, int_count);
      wr(ST, 32'h0);
      rdc("load env", ST, 32'h0);
      $display("test masked done");
   endtask
   task automatic t_den;
      run(17'h00002, 0, 0);
      chk("renorm reg", 1, rn);
      run(17'h08002, 0, 0);
      chk("renorm mem", 0, rn);
      rdc("stat den", ST, 32'h02);
      wr(CM, 32'h1);
      $display("test denormal done");
   endtask
   task automatic t_trap;
      wr(CT, 32'h3B);
      run(17'h00148, 0, 0);
      chk("abort", 1, ab);
      chk("trap", feu_pkg::feu_rsp_trap, rs);
      rdc("irq", ST, 32'h84);
      chk("int on", 1, cpu_int);
      chk("host", 1, int_count);
      wr(CT, 32'hBB);
      repeat (3) @(negedge ref_clk);
      chk("blocked", 0, cpu_int);
      rdc("irq kept", ST, 32'h84);
      wr(CT, 32'h3B);
      repeat (3) @(negedge ref_clk);
      chk("unblocked", 1, cpu_int);
      wr(CM, 32'h1);
      repeat (3) @(negedge ref_clk);
      chk("int off", 0, cpu_int);
      rdc("cleared", ST, 32'h0);
      $display("test trap done");
   endtask
   task automatic t_prio;
      wr(CT, 32'h3D);
      run(17'h01002, 0, 0);
      chk("den first", 1, ab);
      rdc("stat den", ST, 32'h82);
      wr(CM, 32'h1);
      wr(CT, 32'h3B);
      run(17'h003C0, 0, 0);
      chk("inv wins", feu_pkg::feu_rsp_indef, rs);
      chk("no abort", 0, ab);
      rdc("stat inv", ST, 32'h01);
      wr(CM, 32'h1);
      $display("test priority done");
   endtask
   task automatic t_after;
      wr(CT, 32'h37);
      run(0, 4'h8, 15'h7000);
      chk("ovf commit", 1, cm);
      chk("ovf exp", 15'h1000, ad);
      run(17'h10000, 4'h8, 15'h7000);
      chk("store abort", 1, ab);
      wr(CT, 32'h2F);
      run(0, 4'h4, 15'h0100);
      chk("unf exp", 15'h6100, ad);
      wr(CM, 32'h2);
      wr(CT, 32'h1F);
      run(0, 4'h2, 0);
      chk("pre round", feu_pkg::feu_rsp_round, rs);
      repeat (2) @(negedge ref_clk);
      chk("pre int", 1, cpu_int);
      wr(CM, 32'h2);
      rdc("reinit ctrl", CT, 32'h3F);
      rdc("reinit stat", ST, 32'h0);
      $display("test after done");
   endtask
   task automatic t_closure;
      wr(CT, 32'h103F);
      tg <= 17'h00038;
      repeat (2) @(negedge ref_clk);
      chk("affine", 1, infinity_closure_select);
      chk("signed inf", 0, infinities_equal);
      wr(CM, 32'h2);
      repeat (2) @(negedge ref_clk);
      chk("projective", 0, infinity_closure_select);
      chk("unsigned inf", 1, infinities_equal);
      // With the clock enable low the registered compare must hold
      @(posedge ref_clk);
      clk_en <= 1'b0;
      tg <= 17'h0;
      repeat (2) @(negedge ref_clk);
      chk("frozen", 1, infinities_equal);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      $display("test closure done");
   endtask
   initial begin
      {reset_n, avs_read, avs_write, instr_start, result_valid} = 5'h0;
      clk_en = 1'b1;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      {tg, af, result_exp} = 36'h0;
      miscompares = 0;
      tests_run = 0;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset;
      t_masked;
      t_den;
      t_trap;
      t_prio;
      t_after;
      t_closure;
      tally_and_finish;
   end
endmodule // tb_float_exception_unit
bind feu_unit feu_unit_props u_props (.ref_clk, .reset_n, .avs_address, .avs_write,
   .avs_writedata, .avs_waitrequest, .instr_start, .result_valid, .commit_ok, .abort_op,
   .renormalise, .infinity_closure_select, .cpu_int);
